/* File: verilog/bim_cfg.svh */
// Constants for the 32-bit bus input module and its controller
`ifndef BIM_CFG_SVH
`define BIM_CFG_SVH
`define BIM_ADDR_W        8
`define BIM_DATA_W        8
`define BIM_NUM_BYTES     4
// Arbitrary type code value, not taken from any real module
`define BIM_TYPE_CODE     8'ha5
`define BIM_SEL_LO_BIT    0
`define BIM_SEL_HI_BIT    1
`define BIM_CLK_MHZ       50
`define BIM_DESKEW_NS     60
`define BIM_DESKEW_CYC    ((`BIM_DESKEW_NS * `BIM_CLK_MHZ + 999) / 1000)
`define BIM_DIN_NS        60
`define BIM_DIN_CYC       ((`BIM_DIN_NS * `BIM_CLK_MHZ + 999) / 1000)
`define BIM_REPLY_NS      40
`define BIM_REPLY_CYC     ((`BIM_REPLY_NS * `BIM_CLK_MHZ + 999) / 1000)
`define BIM_TIMEOUT_CYC   64
`define BIM_CNT_W         8
`define BIM_CTL_TINV      0
`define BIM_CTL_DIS       1
`define BIM_CTL_GEN       2
`define BIM_CTL_INTA      3
`define BIM_STAT_BUSY     0
`define BIM_STAT_TOUT     1
`define BIM_REG_CTRL      2'h0
`define BIM_REG_ADDR      2'h1
`define BIM_REG_DATA      2'h2
`define BIM_REG_STAT      2'h3
`endif

/* File: verilog/bim_pkg.sv */
// Types shared by the bus input module and its controller
`default_nettype none
package bim_pkg;
  typedef enum logic [2:0] {BIM_IDLE, BIM_ADDR, BIM_SYNC, BIM_WAIT, BIM_DONE} bim_state_e;
endpackage : bim_pkg
`default_nettype wire

/* File: verilog/bim_bus_if.sv */
// Module bus between the input module and its controller
`default_nettype none
interface bim_bus_if;
  logic [7:0] addr;
  logic       sync;
  logic       din;
  logic       int_addr_strobe;
  logic       test_invert_ctrl;
  logic       input_disable_ctrl;
  logic       type_code_select;
  logic [7:0] data;
  logic       data_oe_n;
  logic       bus_reply;
  modport ctl (output addr, sync, din, int_addr_strobe, test_invert_ctrl, input_disable_ctrl,
               type_code_select, input data, data_oe_n, bus_reply);
  modport dev (input addr, sync, din, int_addr_strobe, test_invert_ctrl, input_disable_ctrl,
               type_code_select, output data, data_oe_n, bus_reply);
endinterface : bim_bus_if
`default_nettype wire

/* File: verilog/bim_device.sv */
// 32-bit input module: gating, byte select and read handshake
//
// Functional notes
// RULE_01 - Sample 32 inputs as four bytes
// RULE_02 - No controls: inputs pass unchanged
// RULE_03 - Invert plus disable: all ones
// RULE_04 - Invert alone: inputs inverted
// RULE_05 - Disable alone: all zeros
// RULE_06 - Byte select picks one gated byte
// RULE_07 - Type select returns fixed type code
// RULE_08 - Four consecutive addresses from set base
// RULE_09 - Controller sets address before sync
// RULE_10 - Sync with match: select, mark selected
// RULE_11 - Read strobe and selected drive data
// RULE_12 - Reply follows drive gate after delay
// RULE_13 - Read strobe drop releases data lines
// RULE_14 - Interrupt cycle: strobe, no sync
// RULE_15 - Interrupt strobe clears selected indication
// RULE_16 - Reply drops with drive gate
// RULE_17 - Low address bits choose byte
`include "bim_cfg.svh"
`default_nettype none
module bim_device import bim_pkg::*; #(
  parameter int REPLY_CYC = `BIM_REPLY_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic [31:0] field_in,
  input  wire logic [5:0]  base_sel,
  bim_bus_if.dev           bus
);
  // ****************************************
  // Sizes and elaboration checks
  // ****************************************
  localparam int DATA_W    = `BIM_DATA_W;
  localparam int NUM_BYTES = `BIM_NUM_BYTES;
  localparam int FIELD_W   = DATA_W * NUM_BYTES;
  localparam int SEL_W     = $clog2(NUM_BYTES);
  localparam int ADDR_W    = `BIM_ADDR_W;
  localparam int BASE_W    = ADDR_W - SEL_W;
  localparam int CNT_W     = `BIM_CNT_W;
  localparam int CNT_MAX   = (1 << CNT_W) - 1;
  typedef logic [1:0] bim_sel_t;

  // Reply counter is CNT_W bits; longer delays cannot be served
  if (REPLY_CYC < 1 || REPLY_CYC > CNT_MAX) begin : g_bad_reply
    $error("bim_device: REPLY_CYC out of range");
  end

  if (FIELD_W != $bits(field_in)) begin : g_bad_field
    $error("bim_device: field width disagrees with byte layout");
  end

  if (BASE_W != $bits(base_sel)) begin : g_bad_base
    $error("bim_device: base select width disagrees with address layout");
  end

  if ((1 << SEL_W) != NUM_BYTES || SEL_W != $bits(bim_sel_t)) begin : g_bad_bytes
    $error("bim_device: byte count must match the two byte-select lines");
  end

  if ($bits(`BIM_TYPE_CODE) != DATA_W) begin : g_bad_code
    $error("bim_device: type code width disagrees with data width");
  end

  // ****************************************
  // Helper functions
  // ****************************************
  // Test gating on the whole word
  function automatic logic [FIELD_W-1:0] gate_field(
    input logic [FIELD_W-1:0] raw,
    input logic               invert,
    input logic               dis
  );
    logic [FIELD_W-1:0] res;
    if (invert && dis) begin
      res = '1; // RULE_03
    end else if (invert) begin
      res = ~raw; // RULE_04
    end else if (dis) begin
      res = '0; // RULE_05
    end else begin
      res = raw; // RULE_02
    end
    return res;
  endfunction : gate_field

  // Byte lane chosen by the two select lines
  function automatic logic [DATA_W-1:0] pick_byte(
    input logic [FIELD_W-1:0] word,
    input bim_sel_t           sel
  );
    logic [DATA_W-1:0] res;
    res = '0;
    for (int i = 0; i < NUM_BYTES; i++) begin
      if (sel == SEL_W'(i)) begin
        res = word[i*DATA_W +: DATA_W]; // RULE_17
      end
    end
    return res;
  endfunction : pick_byte

  // Upper address bits against the module's base
  function automatic logic addr_hit(
    input logic [ADDR_W-1:0] a,
    input logic [BASE_W-1:0] base
  );
    return a[ADDR_W-1:SEL_W] == base; // RULE_08
  endfunction : addr_hit

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [FIELD_W-1:0] field;
    logic               byte_sel_lo;
    logic               byte_sel_hi;
    logic               module_selected;
    logic               read_drive_gate;
    logic [CNT_W-1:0]   reply_cnt;
    logic               bus_reply;
    logic [DATA_W-1:0]  data;
    logic               data_oe_n;
  } bim_dev_s;

  // Data lines released out of reset
  localparam bim_dev_s DEV_RESET = '{data_oe_n: 1'b1, default: '0};

  bim_dev_s           st_reg;
  bim_dev_s           st_next;
  logic [FIELD_W-1:0] gated;
  logic [DATA_W-1:0]  sel_byte;
  logic               addr_match;
  logic               drive_next;

  // ****************************************
  // Next-state logic
  // ****************************************
  // Read walk in edges: sync seen -> selection latched; din seen -> gate
  // and drive; REPLY_CYC edges later -> reply; din dropped -> gate, drive
  // and reply fall together on one edge.
  // Field pins are sampled once per clock and gated from that sample, so a
  // pin change reaches the data lines two edges later; the byte is live
  // while driven, not frozen at the start of the read.
  always_comb begin
    st_next = st_reg;
    st_next.field = field_in; // RULE_01
    gated = gate_field(st_reg.field, bus.test_invert_ctrl, bus.input_disable_ctrl);
    sel_byte = pick_byte(gated, {st_reg.byte_sel_hi, st_reg.byte_sel_lo}); // RULE_06
    addr_match = addr_hit(bus.addr, base_sel);
    drive_next = 1'b0;

    // Selection outlives sync; only a new sync or the interrupt-address
    // strobe changes it, so that cycle cannot reuse a stale selection
    if (bus.int_addr_strobe) begin
      st_next.module_selected = 1'b0; // RULE_15
    end else if (bus.sync) begin
      st_next.module_selected = addr_match; // RULE_10
      if (addr_match) begin
        st_next.byte_sel_lo = bus.addr[`BIM_SEL_LO_BIT]; // RULE_17
        st_next.byte_sel_hi = bus.addr[`BIM_SEL_HI_BIT];
      end
    end

    drive_next = bus.din && st_reg.module_selected; // RULE_11
    st_next.read_drive_gate = drive_next;
    st_next.data_oe_n = !drive_next; // RULE_13
    if (bus.type_code_select) begin
      st_next.data = DATA_W'(`BIM_TYPE_CODE); // RULE_07
    end else begin
      st_next.data = sel_byte;
    end

    // Reply waits REPLY_CYC edges of a standing gate
    if (!st_reg.read_drive_gate) begin
      st_next.reply_cnt = '0;
      st_next.bus_reply = 1'b0;
    end else if (st_reg.reply_cnt < CNT_W'(REPLY_CYC - 1)) begin
      st_next.reply_cnt = st_reg.reply_cnt + CNT_W'(1);
    end else begin
      st_next.bus_reply = 1'b1; // RULE_12
    end
    // Reply never outlives the gate, or the controller sees a stale acknowledge
    if (!drive_next) begin
      st_next.bus_reply = 1'b0; // RULE_16
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_reg <= DEV_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // Bus side outputs
  // ****************************************
  assign bus.data      = st_reg.data;
  assign bus.data_oe_n = st_reg.data_oe_n;
  assign bus.bus_reply = st_reg.bus_reply;
endmodule : bim_device
`default_nettype wire

/* File: verilog/bim_controller.sv */
// Controller end: runs read and interrupt-address cycles from registers
`include "bim_cfg.svh"
`default_nettype none
module bim_controller import bim_pkg::*; #(
  parameter int TIMEOUT_CYC = `BIM_TIMEOUT_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  bim_bus_if.ctl          bus
);
  // Wait counter is BIM_CNT_W bits and a cycle needs a few edges to settle
  if (TIMEOUT_CYC < 4 || TIMEOUT_CYC > (1 << `BIM_CNT_W) - 1) begin : g_bad_timeout
    $error("bim_controller: bad TIMEOUT_CYC");
  end

  typedef struct packed {
    bim_state_e state;
    logic [7:0] ctrl;
    logic [7:0] addr;
    logic [7:0] data;
    logic       tout;
    logic [7:0] cnt;
    logic       sync;
    logic       din;
    logic       int_addr;
    logic [7:0] rdata;
  } bim_ctl_s;

  bim_ctl_s st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    st_next.rdata = 8'h0;
    if (reg_rd) begin
      if (reg_addr == `BIM_REG_CTRL) st_next.rdata = st_reg.ctrl;
      else if (reg_addr == `BIM_REG_ADDR) st_next.rdata = st_reg.addr;
      else if (reg_addr == `BIM_REG_DATA) st_next.rdata = st_reg.data;
      else begin
        st_next.rdata[`BIM_STAT_BUSY] = st_reg.state != BIM_IDLE;
        st_next.rdata[`BIM_STAT_TOUT] = st_reg.tout;
      end
    end
    if (reg_wr) begin
      if (reg_addr == `BIM_REG_CTRL) st_next.ctrl = reg_wdata;
      else if (reg_addr == `BIM_REG_ADDR && st_reg.state == BIM_IDLE) begin
        st_next.addr = reg_wdata;
        st_next.tout = 1'b0;
        st_next.int_addr = st_reg.ctrl[`BIM_CTL_INTA];
        st_next.cnt = 8'h0;
        st_next.state = BIM_ADDR;
      end
    end
    case (st_reg.state)
      BIM_ADDR: begin
        st_next.cnt = st_reg.cnt + 8'h1;
        if (st_reg.cnt >= 8'(`BIM_DESKEW_CYC - 1)) begin
          st_next.sync = !st_reg.int_addr; // RULE_09 RULE_14
          st_next.cnt = 8'h0;
          st_next.state = BIM_SYNC;
        end
      end
      BIM_SYNC: begin
        st_next.cnt = st_reg.cnt + 8'h1;
        if (st_reg.cnt >= 8'(`BIM_DIN_CYC - 1)) begin
          st_next.din = 1'b1; // RULE_11
          st_next.cnt = 8'h0;
          st_next.state = BIM_WAIT;
        end
      end
      BIM_WAIT: begin
        st_next.cnt = st_reg.cnt + 8'h1;
        if (bus.bus_reply) begin
          st_next.data = bus.data;
          st_next.din = 1'b0; // RULE_13
          st_next.state = BIM_DONE;
        end else if (st_reg.cnt >= 8'(TIMEOUT_CYC - 1)) begin
          st_next.tout = 1'b1;
          st_next.din = 1'b0;
          st_next.state = BIM_DONE;
        end
      end
      BIM_DONE: begin
        if (!bus.bus_reply) begin
          st_next.sync = 1'b0;
          st_next.int_addr = 1'b0;
          st_next.state = BIM_IDLE;
        end
      end
      default: ;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) st_reg <= '0;
    else st_reg <= st_next;
  end

  assign reg_rdata = st_reg.rdata;
  assign bus.addr = st_reg.addr;
  assign bus.sync = st_reg.sync;
  assign bus.din = st_reg.din;
  assign bus.int_addr_strobe = st_reg.int_addr && st_reg.state != BIM_IDLE; // RULE_14
  assign bus.test_invert_ctrl = st_reg.ctrl[`BIM_CTL_TINV];
  assign bus.input_disable_ctrl = st_reg.ctrl[`BIM_CTL_DIS];
  assign bus.type_code_select = st_reg.ctrl[`BIM_CTL_GEN];
endmodule : bim_controller
`default_nettype wire

/* File: test/bim_chk.sv */
// Bus checker for the input module and its controller
`include "bim_cfg.svh"
`default_nettype none
module bim_chk (
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic [31:0] field_in,
  input wire logic [5:0]  base_sel,
  input wire logic [7:0]  addr,
  input wire logic        sync,
  input wire logic        din,
  input wire logic        int_addr_strobe,
  input wire logic        test_invert_ctrl,
  input wire logic        input_disable_ctrl,
  input wire logic        type_code_select,
  input wire logic [7:0]  data,
  input wire logic        data_oe_n,
  input wire logic        bus_reply
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] raw;
  logic [7:0] want;
  logic       hit;
  assign raw = field_in[{addr[1:0], 3'h0} +: 8];
  assign hit = addr[7:2] == base_sel;
  always_comb begin
    want = raw;
    if (test_invert_ctrl && input_disable_ctrl) want = 8'hff;
    else if (test_invert_ctrl) want = ~raw;
    else if (input_disable_ctrl) want = 8'h00;
    if (type_code_select) want = `BIM_TYPE_CODE;
  end
  // ****************************************
  // Handshake and data relations
  // ****************************************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  property p_deskew; $rose(sync) |-> $past(addr, 3) == addr; endproperty
  a_deskew: assert property (p_deskew) else $error("addr moved before sync");
  property p_drive; $rose(din) && sync && hit |=> !data_oe_n; endproperty
  a_drive: assert property (p_drive) else $error("no drive gate");
  property p_foreign; din && sync && !hit |=> data_oe_n; endproperty
  a_foreign: assert property (p_foreign) else $error("foreign address drove");
  property p_reply; $fell(data_oe_n) |-> !bus_reply ##2 bus_reply; endproperty
  a_reply: assert property (p_reply) else $error("reply timing");
  property p_release; $fell(din) |=> data_oe_n && !bus_reply; endproperty
  a_release: assert property (p_release) else $error("bus not released");
  property p_gate_reply; bus_reply |-> !data_oe_n; endproperty
  a_gate_reply: assert property (p_gate_reply) else $error("reply without gate");
  property p_data; !data_oe_n |-> data == want; endproperty
  a_data: assert property (p_data) else $error("wrong byte");
  property p_inta_clear; int_addr_strobe |=> data_oe_n [*6]; endproperty
  a_inta_clear: assert property (p_inta_clear) else $error("drive in interrupt-address cycle");
  property p_inta_nosync; int_addr_strobe |-> !sync; endproperty
  a_inta_nosync: assert property (p_inta_nosync) else $error("sync in interrupt-address cycle");
  cover property ($fell(bus_reply));
  cover property (int_addr_strobe && din);
  cover property (din && sync && !hit);
endmodule : bim_chk
`default_nettype wire

/* File: test/tb_bus_input_module_32bit.sv */
// Self-checking bench for the input module and its controller
`include "bim_cfg.svh"
`default_nettype none
module tb_bus_input_module_32bit;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [5:0] BASE = 6'h2d;
  logic        sys_clk;
  logic        reset;
  logic [31:0] field;
  logic [1:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic [7:0]  st;
  logic [7:0]  d;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          cyc = 0;
  bim_bus_if bus ();
  bim_device #(.REPLY_CYC(2)) i_bim_device (.sys_clk(sys_clk), .reset(reset), .field_in(field),
    .base_sel(BASE), .bus(bus));
  bim_controller #(.TIMEOUT_CYC(8)) i_bim_controller (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus(bus));
  bim_chk i_bim_chk (.sys_clk(sys_clk), .reset(reset), .field_in(field), .base_sel(BASE), .addr(bus.addr),
    .sync(bus.sync), .din(bus.din), .int_addr_strobe(bus.int_addr_strobe), .test_invert_ctrl(bus.test_invert_ctrl),
    .input_disable_ctrl(bus.input_disable_ctrl), .type_code_select(bus.type_code_select),
    .data(bus.data), .data_oe_n(bus.data_oe_n), .bus_reply(bus.bus_reply));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Whole run needs about 770 cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  // ****************************************
  // Bus tasks and scenarios
  // ****************************************
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    v = reg_rdata;
  endtask : rd
  // Polls busy under a bound so a stuck cycle cannot hang the bench
  task automatic xfer(input logic [7:0] ctl, input logic [7:0] a);
    wr(2'h0, ctl);
    wr(2'h1, a);
    for (int i = 0; i < 40; i++) begin
      rd(2'h3, st);
      if (st[0] === 1'b0) break;
    end
    chk({7'h00, st[0]}, 8'h00);
    rd(2'h2, d);
  endtask : xfer
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [7:0] gate(input logic [7:0] x, input logic [1:0] c);
    case (c)
      2'h0: return x;
      2'h1: return ~x;
      2'h2: return 8'h00;
      default: return 8'hff;
    endcase
  endfunction : gate
  task automatic t_gating;
    for (int c = 0; c < 4; c++) begin
      for (int b = 0; b < 4; b++) begin
        xfer({6'h00, c[1:0]}, {BASE, b[1:0]});
        chk(d, gate(field[b*8 +: 8], c[1:0]));
      end
    end
  endtask : t_gating
  task automatic t_misc;
    xfer(8'h05, {BASE, 2'h3});
    chk(d, `BIM_TYPE_CODE);
    rd(`BIM_REG_CTRL, d);
    chk(d, 8'h05);
    rd(`BIM_REG_ADDR, d);
    chk(d, {BASE, 2'h3});
    // Selection still stands from the read above; the strobe alone must clear it
    xfer(8'h08, {BASE, 2'h1});
    chk({7'h00, st[1]}, 8'h01);
    xfer(8'h00, {BASE - 6'h01, 2'h3});
    chk({7'h00, st[1]}, 8'h01);
    xfer(8'h00, {BASE + 6'h01, 2'h0});
    chk({7'h00, st[1]}, 8'h01);
    xfer(8'h00, {BASE, 2'h2});
    chk(d, field[23:16]);
  endtask : t_misc
  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    reset = 1'b1;
    field = 32'h8e31c45b;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    t_gating();
    @(posedge sys_clk);
    field <= 32'h17e26ad9;
    t_gating();
    t_misc();
    give_verdict();
  end
endmodule : tb_bus_input_module_32bit
`default_nettype wire
